//--- css_pkg.sv
/*
  Shared constants and carrier types for the completion stream sideband framer.
  Assumes a 512-bit beat split into four 128-bit segments of four Dwords each.
*/
`default_nettype none
package css_pkg;
  localparam int DATA_W = 512;
  localparam int BYTES = DATA_W / 8;
  localparam int SEGS = 4;
  localparam int SEG_DW_W = 2;
  localparam int SB_W = 161;
  // Start lane codes for byte lanes 0, 16, 32 and 48
  localparam logic [1:0] LANE_0 = 2'h0;
  localparam logic [1:0] LANE_16 = 2'h1;
  localparam logic [1:0] LANE_32 = 2'h2;
  localparam logic [1:0] LANE_48 = 2'h3;
  localparam logic [3:0] FLAGS_NONE = 4'h0;
  localparam logic RST_ABORT = 1'b0;
  localparam logic RST_VALID = 1'b0;

  // Beat as it leaves the internal completion buffer
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] byte_en;
    logic [SEGS-1:0] start_seg;
    logic [SEGS-1:0] end_seg;
    logic [SEGS-1:0][SEG_DW_W-1:0] end_dw;
    logic end_has_payload;
    logic rd_err;
  } css_in_beat_t;

  // Sideband word, high field first; byte_en last, at bit 0
  typedef struct packed {
    logic [BYTES-1:0] parity;
    logic abort;
    logic [SEGS-1:0][3:0] end_offset;
    logic [SEGS-1:0] packet_end_flags;
    logic [SEGS-1:0][1:0] start_lane;
    logic [SEGS-1:0] packet_start_flags;
    logic [BYTES-1:0] byte_en;
  } css_sideband_t;
endpackage
`default_nettype wire

//--- css_parity.sv
/*
  Per-byte odd parity over one data beat.
  Assumes a purely combinational use; the caller registers the result.
*/
`default_nettype none
module css_parity #(
  parameter int BYTES = 64
) (
  // Data in
  input wire logic [BYTES*8-1:0] data,
  // Parity out
  output logic [BYTES-1:0] parity
);
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      // Odd parity: set when the byte has an even count of ones
      assign parity[i] = ~(^data[i*8 +: 8]);
    end
  endgenerate
endmodule
`default_nettype wire

//--- css_framer.sv
/*
  Completion stream sideband framer: registers one beat from the completion
  buffer and drives data, sideband and last-beat flag on a valid/ready stream.
  Assumes the buffer presents segment-aligned start/end marks and that the
  multi-packet option and endpoint mode are fixed at build time.
*/
// Summary of operation
// - First start lane coded 00,01,10,11
// - Single-packet mode: first start lane zero
// - Second start lane only 16, 32, 48
// - Third start lane only 32 or 48
// - Fourth start lane only lane 48
// - Single-packet mode: other lanes, offsets zero
// - End flags are thermometer code of endings
// - First ending packet offset in field zero
// - Later ending offsets in own fields
// - Single-packet mode marks end with last-beat
// - Abort on payload read error, last beat
// - No abort without payload; multi mode only with end bit0
// - Multi-packet mode: no new packet in an abort beat
// - Endpoint reports abort through error reporting
// - Parity bit i odd over byte i
// - Start flags thermometer; single mode bit0 only
// - Transfer on valid and ready; hold otherwise
`default_nettype none
module css_framer #(
  parameter bit MULTI_PKT_EN = 1'b1,
  parameter bit IS_ENDPOINT = 1'b1
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Beat from completion buffer
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire css_pkg::css_in_beat_t IN_BEAT,
  // Completion stream to user logic
  output logic COMPLETION_VALID,
  input wire logic COMPLETION_READY,
  output logic [css_pkg::DATA_W-1:0] COMPLETION_DATA,
  output css_pkg::css_sideband_t COMPLETION_SIDEBAND,
  output logic COMPLETION_LAST_BEAT,
  // Error reporting toward the link
  output logic AER_ABORT_REPORT
);
  import css_pkg::*;

  // Option is a parameter so it cannot move while packets are in flight
  initial begin
    if ($bits(css_sideband_t) != SB_W) begin
      $error("css_framer: sideband width mismatch");
    end
    if (SEGS != 4 || DATA_W != 512) begin
      $error("css_framer: only a 512-bit beat of four segments is served");
    end
  end

  typedef enum logic [1:0] {
    S_PASS = 2'b01,
    S_SPLIT = 2'b10
  } css_state_t;

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  css_state_t state_q;
  logic out_valid_q;
  logic [DATA_W-1:0] out_data_q;
  css_sideband_t out_sb_q;
  logic out_last_q;
  logic [SEGS-1:0] hold_flags_q;
  logic [SEGS-1:0][1:0] hold_lane_q;
  logic aer_q;
  logic [BYTES-1:0] in_parity;
  css_sideband_t frame_d;
  logic out_free;
  logic take;
  logic split_d;
  logic sent;

  // Reset is released through two flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  css_parity #(
    .BYTES(BYTES)
  ) u_parity (
    .data(IN_BEAT.data),
    .parity(in_parity)
  );

  function automatic logic [3:0] therm(input logic [2:0] n);
    therm = 4'((5'h01 << n) - 5'h01);
  endfunction

  // Compact segment marks into ordered fields
  always_comb begin
    logic [2:0] ns;
    logic [2:0] ne;
    ns = 3'h0;
    ne = 3'h0;
    frame_d = '0;
    frame_d.byte_en = IN_BEAT.byte_en;
    frame_d.parity = in_parity;
    if (MULTI_PKT_EN) begin
      for (int k = 0; k < SEGS; k++) begin
        if (IN_BEAT.start_seg[k]) begin
          // Slot n can only see segment n or later
          frame_d.start_lane[ns[1:0]] = 2'(k);
          ns = ns + 3'h1;
        end
        if (IN_BEAT.end_seg[k]) begin
          // Offset is segment in the top bits, Dword in the low
          frame_d.end_offset[ne[1:0]] = {2'(k), IN_BEAT.end_dw[k]};
          ne = ne + 3'h1;
        end
      end
      frame_d.packet_start_flags = therm(ns);
      frame_d.packet_end_flags = therm(ne);
    end else begin
      // Lanes, offsets and upper flags stay zero
      frame_d.packet_start_flags[0] = |IN_BEAT.start_seg;
    end
    // Abort only on a beat ending a packet that carries payload
    frame_d.abort = IN_BEAT.rd_err & IN_BEAT.end_has_payload & (|IN_BEAT.end_seg);
  end

  assign out_free = !out_valid_q || COMPLETION_READY;
  assign IN_READY = (state_q == S_PASS) && out_free;
  assign take = IN_VALID && IN_READY;
  // With the multi-packet option, starts riding with an abort are pushed into a second beat
  assign split_d = MULTI_PKT_EN && frame_d.abort && (frame_d.packet_start_flags != FLAGS_NONE);
  assign sent = out_valid_q && COMPLETION_READY;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_PASS;
    end else begin
      case (state_q)
        S_PASS: begin
          if (take && split_d) begin
            state_q <= S_SPLIT;
          end
        end
        S_SPLIT: begin
          if (out_free) begin
            state_q <= S_PASS;
          end
        end
        default: begin
          state_q <= S_PASS;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= RST_VALID;
    end else if (take || (state_q == S_SPLIT && out_free)) begin
      out_valid_q <= 1'b1;
    end else if (sent) begin
      out_valid_q <= 1'b0;
    end
  end

  // Data and sideband hold while ready is low
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      out_data_q <= '0;
      out_sb_q <= '0;
      out_last_q <= 1'b0;
    end else if (take) begin
      out_data_q <= IN_BEAT.data;
      out_sb_q <= frame_d;
      // Last-beat flag only without the multi-packet option
      out_last_q <= !MULTI_PKT_EN && (|IN_BEAT.end_seg);
      if (split_d) begin
        out_sb_q.packet_start_flags <= FLAGS_NONE;
        out_sb_q.start_lane <= '0;
      end
    end else if (state_q == S_SPLIT && out_free) begin
      // Same data resent; lanes ahead of the first start belong to no packet
      out_sb_q.packet_start_flags <= hold_flags_q;
      out_sb_q.start_lane <= hold_lane_q;
      out_sb_q.packet_end_flags <= FLAGS_NONE;
      out_sb_q.end_offset <= '0;
      out_sb_q.abort <= RST_ABORT;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_flags_q <= FLAGS_NONE;
      hold_lane_q <= '0;
    end else if (take && split_d) begin
      hold_flags_q <= frame_d.packet_start_flags;
      hold_lane_q <= frame_d.start_lane;
    end
  end

  // Endpoint flags each delivered abort to the error reporting logic
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      aer_q <= 1'b0;
    end else begin
      aer_q <= IS_ENDPOINT && sent && out_sb_q.abort;
    end
  end

  assign COMPLETION_VALID = out_valid_q;
  assign COMPLETION_DATA = out_data_q;
  assign COMPLETION_SIDEBAND = out_sb_q;
  assign COMPLETION_LAST_BEAT = out_last_q;
  assign AER_ABORT_REPORT = aer_q;
endmodule
`default_nettype wire

//--- css_framer_monitor.sv
/*
  Checker for the framer's output stream and sideband.
  Assumes the multi-packet build and binding onto css_framer.
*/
`default_nettype none
module css_framer_monitor
  import css_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Completion stream
  input wire logic COMPLETION_VALID,
  input wire logic COMPLETION_READY,
  input wire logic [DATA_W-1:0] COMPLETION_DATA,
  input wire css_sideband_t COMPLETION_SIDEBAND,
  input wire logic COMPLETION_LAST_BEAT,
  input wire logic AER_ABORT_REPORT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic v;
  css_sideband_t s;
  logic [BYTES-1:0] par;
  assign v = COMPLETION_VALID;
  assign s = COMPLETION_SIDEBAND;
  always_comb for (int i = 0; i < BYTES; i++) par[i] = ~^COMPLETION_DATA[8*i+:8];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_hold; v && !COMPLETION_READY |=> v && $stable(s) && $stable(COMPLETION_DATA); endproperty
  a_hold: assert property (p_hold) else $error("beat changed while stalled");
  property p_sfl; v |-> s.packet_start_flags inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}; endproperty
  a_sfl: assert property (p_sfl) else $error("start flags not thermometer");
  property p_efl; v |-> s.packet_end_flags inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}; endproperty
  a_efl: assert property (p_efl) else $error("end flags not thermometer");
  property p_lane; v && s.packet_start_flags[1] |-> s.start_lane[1] > s.start_lane[0]; endproperty
  a_lane: assert property (p_lane) else $error("second lane bad");
  property p_third; v && s.packet_start_flags[2] |-> s.start_lane[2][1]; endproperty
  a_third: assert property (p_third) else $error("third lane bad");
  property p_fourth; v && s.packet_start_flags[3] |-> s.start_lane[3] == LANE_48; endproperty
  a_fourth: assert property (p_fourth) else $error("fourth lane bad");
  property p_last; v |-> !COMPLETION_LAST_BEAT; endproperty
  a_last: assert property (p_last) else $error("last beat used");
  property p_abort; v && s.abort |-> s.packet_end_flags[0] && s.packet_start_flags == 4'h0; endproperty
  a_abort: assert property (p_abort) else $error("abort beat bad");
  property p_aer; v && COMPLETION_READY && s.abort |=> AER_ABORT_REPORT; endproperty
  a_aer: assert property (p_aer) else $error("abort not reported");
  property p_par; v |-> s.parity == par; endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  c_four: cover property (v && s.packet_start_flags == 4'hF);
  c_abort: cover property (v && COMPLETION_READY && s.abort);
  c_stall: cover property (v && !COMPLETION_READY);
endmodule
`default_nettype wire

//--- css_sink.sv
/*
  User-side receiver model pacing the completion stream.
  Assumes the same clock as the framer; slow mode stalls three of four cycles.
*/
`default_nettype none
module css_sink (
  // Clock and pacing mode
  input wire logic MCLK,
  input wire logic slow,
  // Completion stream
  input wire logic COMPLETION_VALID,
  output logic COMPLETION_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  // Free-running pacing count; no reset, so it starts from its declared value
  logic [1:0] cnt_q = 2'h0;
  always @(posedge MCLK) cnt_q <= cnt_q + 2'h1;
  // In slow mode ready rises only with valid on count 3, so a stalled beat must be held
  assign COMPLETION_READY = !slow || (cnt_q == 2'h3 && COMPLETION_VALID);
endmodule
`default_nettype wire

//--- test_completion_stream_sideband.sv
/*
  Bench for the sideband framer with the multi-packet build.
  Assumes css_framer, css_sink and the checker are compiled before it.
*/
`default_nettype none
module test_completion_stream_sideband;
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;
  logic MCLK = 1'b0, RST_N = 1'b0, IN_VALID = 1'b0, slow = 1'b1;
  logic IN_READY, COMPLETION_VALID, COMPLETION_READY, LAST, AER;
  logic [DATA_W-1:0] DATA;
  css_in_beat_t IN_BEAT = '0;
  css_sideband_t SB;
  logic [96:0] got_q[$];
  int miscompares = 0, samples_checked = 0, dropped = 0;
  initial forever #20 MCLK = ~MCLK;
  css_framer uut (.MCLK(MCLK), .RST_N(RST_N), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
    .IN_BEAT(IN_BEAT), .COMPLETION_VALID(COMPLETION_VALID), .COMPLETION_READY(COMPLETION_READY),
    .COMPLETION_DATA(DATA), .COMPLETION_SIDEBAND(SB), .COMPLETION_LAST_BEAT(LAST),
    .AER_ABORT_REPORT(AER));
  css_sink sink (.MCLK(MCLK), .slow(slow), .COMPLETION_VALID(COMPLETION_VALID),
    .COMPLETION_READY(COMPLETION_READY));
  always @(posedge MCLK) if (COMPLETION_VALID && COMPLETION_READY) got_q.push_back(SB[96:0]);
  // Receiver side: an aborted beat discards its packet; data must match what was sent
  always @(posedge MCLK) begin
    if (COMPLETION_VALID && COMPLETION_READY) begin
      if (SB.abort) dropped++;
      samples_checked++;
      if (DATA !== {16{32'h5A3C96E1}}) begin
        miscompares++;
        $display("CHECK FAILED %0t data mismatch", $time);
      end
    end
  end
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic [3:0] st, en, input logic [7:0] dw, input logic pay, err);
    int n = 0;
    IN_BEAT <= '{data: {16{32'h5A3C96E1}}, byte_en: 64'h0FFF, start_seg: st, end_seg: en,
      end_dw: dw, end_has_payload: pay, rd_err: err};
    IN_VALID <= 1'b1;
    do begin @(negedge MCLK); n++; end while (!IN_READY && n < 50);
    if (!IN_READY) begin
      miscompares++;
      $display("CHECK FAILED %0t input never accepted", $time);
      complete_run();
    end else begin
      @(posedge MCLK);
    end
  endtask
  function automatic logic [96:0] e(logic ab, logic [15:0] eo, logic [3:0] ef, logic [7:0] sl,
      logic [3:0] sf);
    return {ab, eo, ef, sl, sf, 64'h0FFF};
  endfunction
  task automatic chk(input logic [96:0] exp);
    int n = 0;
    while (got_q.size() == 0 && n < 50) begin @(negedge MCLK); n++; end
    samples_checked++;
    if (got_q.size() == 0 || got_q[0] !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t sideband mismatch", $time);
    end
    if (got_q.size() == 0) complete_run();
    else void'(got_q.pop_front());
  endtask
  task automatic t_lanes();
    send(4'hF, 4'h0, 8'h00, 1'b0, 1'b0);
    send(4'hA, 4'h0, 8'h00, 1'b0, 1'b0);
    send(4'hE, 4'h0, 8'h00, 1'b0, 1'b0);
    IN_VALID <= 1'b0;
    chk(e(1'b0, 16'h0, 4'h0, 8'hE4, 4'hF));
    chk(e(1'b0, 16'h0, 4'h0, 8'h0D, 4'h3));
    chk(e(1'b0, 16'h0, 4'h0, 8'h39, 4'h7));
    $display("test lanes done");
  endtask
  task automatic t_ends();
    @(posedge MCLK);
    send(4'h0, 4'hB, 8'hC9, 1'b1, 1'b0);
    send(4'h0, 4'hF, 8'h00, 1'b1, 1'b0);
    IN_VALID <= 1'b0;
    chk(e(1'b0, 16'h0F61, 4'h7, 8'h00, 4'h0));
    chk(e(1'b0, 16'hC840, 4'hF, 8'h00, 4'h0));
    $display("test ends done");
  endtask
  task automatic t_abort();
    @(posedge MCLK);
    slow <= 1'b0;
    send(4'h4, 4'h1, 8'h03, 1'b1, 1'b1);
    send(4'h0, 4'h1, 8'h03, 1'b0, 1'b1);
    IN_VALID <= 1'b0;
    chk(e(1'b1, 16'h0003, 4'h1, 8'h00, 4'h0));
    chk(e(1'b0, 16'h0000, 4'h0, 8'h02, 4'h1));
    chk(e(1'b0, 16'h0003, 4'h1, 8'h00, 4'h0));
    samples_checked++;
    if (dropped != 1) begin
      miscompares++;
      $display("CHECK FAILED %0t dropped packet count wrong", $time);
    end
    $display("test abort done");
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_lanes();
    t_ends();
    t_abort();
    complete_run();
  end
endmodule
bind css_framer css_framer_monitor mon (.MCLK(MCLK), .RST_N(RST_N),
  .COMPLETION_VALID(COMPLETION_VALID), .COMPLETION_READY(COMPLETION_READY),
  .COMPLETION_DATA(COMPLETION_DATA), .COMPLETION_SIDEBAND(COMPLETION_SIDEBAND),
  .COMPLETION_LAST_BEAT(COMPLETION_LAST_BEAT), .AER_ABORT_REPORT(AER_ABORT_REPORT));
`default_nettype wire
